// File: hdl/cfa_regs.vh
`ifndef CFA_REGS_VH
`define CFA_REGS_VH
// Register byte offsets.
`define CFA_OPER_OFS    8'h00
`define CFA_CMD_OFS     8'h04
`define CFA_FLAGS_OFS   8'h08
`define CFA_INSN_OFS    8'h0C
`define CFA_INDEX_OFS   8'h10
`define CFA_PC_OFS      8'h14
`define CFA_ACTL_OFS    8'h18
`define CFA_EA_OFS      8'h1C
`define CFA_CYC_OFS     8'h20
`define CFA_RES_OFS     8'h24
// Flag bit positions.
`define CFA_F_S 7
`define CFA_F_X 6
`define CFA_F_H 5
`define CFA_F_I 4
`define CFA_F_N 3
`define CFA_F_Z 2
`define CFA_F_V 1
`define CFA_F_C 0
`define CFA_FLAGS_RST   8'hD0
// Command codes.
`define CFA_OP_ADD      4'h0
`define CFA_OP_ADC      4'h1
`define CFA_OP_SUB      4'h2
`define CFA_OP_SBC      4'h3
`define CFA_OP_AND      4'h4
`define CFA_OP_ORA      4'h5
`define CFA_OP_EOR      4'h6
`define CFA_OP_LSL      4'h7
`define CFA_OP_LSR      4'h8
`define CFA_OP_ASR      4'h9
`define CFA_OP_ROL      4'hA
`define CFA_OP_ROR      4'hB
`define CFA_OP_SUMACC   4'hC
`define CFA_OP_TAP      4'hD
`define CFA_OP_RETURN   4'hE
`define CFA_OP_STOP     4'hF
// Addressing modes.
`define CFA_M_IMM       3'h0
`define CFA_M_DIR       3'h1
`define CFA_M_EXT       3'h2
`define CFA_M_IDX       3'h3
`define CFA_M_INH       3'h4
`define CFA_M_REL       3'h5
// Prebytes.
`define CFA_PRE_P2      8'h18
`define CFA_PRE_P3      8'h1A
`define CFA_PRE_P4      8'hCD
// Base E-clock cycles per addressing mode.
`define CFA_CYC_IMM     4'h2
`define CFA_CYC_DIR     4'h3
`define CFA_CYC_EXT     4'h4
`define CFA_CYC_IDX     4'h4
`define CFA_CYC_INH     4'h2
`define CFA_CYC_REL     4'h3
`define CFA_MSRC        2
`endif

// File: hdl/cfa_flag_alu.v
`timescale 1ns/1ps
`include "cfa_regs.vh"
module cfa_flag_alu (
  input  wire [3:0] op,
  input  wire [7:0] a,
  input  wire [7:0] b,
  input  wire [7:0] flags_in,
  output reg  [7:0] res,
  output reg  [7:0] flags_out
);
  reg [8:0] sum9;
  reg       cin;
  reg       arith;
  reg       is_sub;
  reg       upd;
  always @* begin
    cin = flags_in[`CFA_F_C];
    sum9 = 9'h000;
    arith = 1'b0;
    is_sub = 1'b0;
    upd = 1'b1;
    res = a;
    flags_out = flags_in;
    case (op)
      `CFA_OP_ADD, `CFA_OP_SUMACC: begin
        sum9 = {1'b0, a} + {1'b0, b};
        arith = 1'b1;
      end
      `CFA_OP_ADC: begin
        sum9 = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        arith = 1'b1;
      end
      `CFA_OP_SUB: begin
        sum9 = {1'b0, a} - {1'b0, b};
        arith = 1'b1;
        is_sub = 1'b1;
      end
      `CFA_OP_SBC: begin
        sum9 = {1'b0, a} - {1'b0, b} - {8'h00, cin};
        arith = 1'b1;
        is_sub = 1'b1;
      end
      `CFA_OP_AND: res = a & b;
      `CFA_OP_ORA: res = a | b;
      `CFA_OP_EOR: res = a ^ b;
      `CFA_OP_LSL: res = {a[6:0], 1'b0};
      `CFA_OP_LSR: res = {1'b0, a[7:1]};
      `CFA_OP_ASR: res = {a[7], a[7:1]};
      `CFA_OP_ROL: res = {a[6:0], cin};
      `CFA_OP_ROR: res = {cin, a[7:1]};
      default: upd = 1'b0;
    endcase
    if (arith) begin
      res = sum9[7:0];
      flags_out[`CFA_F_C] = sum9[8];
      if (is_sub) begin
        flags_out[`CFA_F_V] = (a[7] ^ b[7]) & (res[7] ^ a[7]);
      end else begin
        flags_out[`CFA_F_V] = ~(a[7] ^ b[7]) & (res[7] ^ a[7]);
        flags_out[`CFA_F_H] = a[4] ^ b[4] ^ res[4];
      end
    end else if (upd && op >= `CFA_OP_LSL) begin
      flags_out[`CFA_F_C] = (op == `CFA_OP_LSL || op == `CFA_OP_ROL) ? a[7] : a[0];
      flags_out[`CFA_F_V] = res[7] ^ flags_out[`CFA_F_C];
    end else if (upd) begin
      flags_out[`CFA_F_V] = 1'b0;
    end
    if (upd) begin
      flags_out[`CFA_F_Z] = (res == 8'h00);
      flags_out[`CFA_F_N] = res[7];
    end
  end
endmodule

// File: hdl/cfa_ea_gen.v
`timescale 1ns/1ps
`include "cfa_regs.vh"
module cfa_ea_gen (
  input  wire [31:0] insn,
  input  wire [15:0] pc,
  input  wire [15:0] ix,
  input  wire [15:0] iy,
  input  wire [2:0]  mode,
  input  wire        use_y,
  input  wire        wide,
  input  wire        taken,
  output reg  [15:0] ea,
  output reg  [15:0] next_pc,
  output reg  [1:0]  page,
  output reg  [2:0]  len,
  output reg         mem_ref,
  output reg  [3:0]  cycles
);
  wire       pre = (insn[7:0] == `CFA_PRE_P2) || (insn[7:0] == `CFA_PRE_P3) ||
                   (insn[7:0] == `CFA_PRE_P4);
  wire [7:0] ob1 = pre ? insn[23:16] : insn[15:8];
  wire [7:0] ob2 = pre ? insn[31:24] : insn[23:16];
  wire [2:0] pl  = {2'b00, pre};
  always @* begin
    page = 2'd0;
    if (insn[7:0] == `CFA_PRE_P2) page = 2'd1;
    if (insn[7:0] == `CFA_PRE_P3) page = 2'd2;
    if (insn[7:0] == `CFA_PRE_P4) page = 2'd3;
    mem_ref = 1'b1;
    ea = 16'h0000;
    len = 3'd2 + pl;
    cycles = `CFA_CYC_INH;
    case (mode)
      `CFA_M_IMM: begin
        ea = pc + {15'h0000, pre} + 16'h0001;
        len = (wide ? 3'd3 : 3'd2) + pl;
        cycles = `CFA_CYC_IMM + {3'b000, wide};
      end
      `CFA_M_DIR: begin
        ea = {8'h00, ob1};
        cycles = `CFA_CYC_DIR;
      end
      `CFA_M_EXT: begin
        ea = {ob1, ob2};
        len = 3'd3 + pl;
        cycles = `CFA_CYC_EXT;
      end
      `CFA_M_IDX: begin
        ea = (use_y ? iy : ix) + {8'h00, ob1};
        cycles = `CFA_CYC_IDX;
      end
      `CFA_M_REL: begin
        ea = pc + {13'h0000, len} + {{8{ob1[7]}}, ob1};
        mem_ref = 1'b0;
        cycles = `CFA_CYC_REL;
      end
      default: begin
        len = 3'd1 + pl;
        mem_ref = 1'b0;
      end
    endcase
    cycles = cycles + {3'b000, pre};
    next_pc = pc + {13'h0000, len};
    if (mode == `CFA_M_REL && taken) next_pc = ea;
  end
endmodule

// File: hdl/cfa_core.v
// Operation
// - Carry is set by a carry or borrow out of the ALU and is also updated by shifts and rotates.
// - Overflow is set on two's complement overflow and cleared otherwise; shifts and rotates instead load it with N xor C.
// - Zero is set when an arithmetic, logic or data result is zero and cleared otherwise.
// - Negative follows the most significant bit of the result.
// - While the maskable mask bit is one every maskable source is blocked.
// - Half carry records a carry from bit 3 into bit 4 on the add family only.
// - The nonmaskable mask is set only by reset or acknowledge, cleared only by TAP or return.
// - With stop disable set the stop command does nothing; clear, it stops.
// - Immediate operands follow the opcode and are as wide as the target register.
// - Direct mode forms the address from one byte with a zero high byte.
// - Extended mode takes a full 16-bit address from the two bytes after the opcode.
// - Indexed mode adds an unsigned 8-bit offset to the X or Y index register.
// - Inherent instructions use registers only and make no memory reference.
// - A taken branch adds the sign-extended offset to the program counter.
// - No prebyte is page 1; 18, 1A and CD select pages 2, 3 and 4.
// - Each mode has one base cycle count in E-clock cycles; a 16-bit immediate and a prebyte each add one cycle.
`timescale 1ns/1ps
`include "cfa_regs.vh"
module cfa_core (
  input  wire                 ref_clk,
  input  wire                 reset,
  input  wire                 psel,
  input  wire                 penable,
  input  wire                 pwrite,
  input  wire [7:0]           paddr,
  input  wire [31:0]          pwdata,
  output reg  [31:0]          prdata,
  output reg                  pready,
  output reg                  pslverr,
  input  wire                 nonmaskable_request_pin_n,
  input  wire [`CFA_MSRC-1:0] maskable_req,
  output wire [`CFA_MSRC-1:0] maskable_ack,
  output wire                 nonmaskable_ack,
  output reg                  stop_enter,
  output reg  [7:0]           flags_register
);

////////////////////////////////////////////////////////////////////////////////

  localparam ST_IDLE   = 3'b001;
  localparam ST_DECODE = 3'b010;
  localparam ST_LATCH  = 3'b100;

  reg  [15:0] oper_q;
  reg  [7:0]  res_q;
  reg  [31:0] insn_q;
  reg  [15:0] ix_q;
  reg  [15:0] iy_q;
  reg  [15:0] pc_q;
  reg  [8:0]  actl_q;
  reg  [15:0] ea_q;
  reg  [1:0]  page_q;
  reg  [2:0]  len_q;
  reg         mref_q;
  reg  [3:0]  cyc_last_q;
  reg  [15:0] cyc_sum_q;
  reg         stop_nop_q;
  reg  [3:0]  last_op_q;
  reg  [2:0]  state_q;
  reg  [2:0]  state_d;
  reg  [7:0]  flags_d;
  reg         taken;
  reg  [31:0] rd_mux;
  reg         rd_ok;

  wire        setup   = psel & ~penable;
  wire        wr_en   = psel & penable & pwrite & pready;
  wire [3:0]  cmd_op  = pwdata[3:0];
  wire        cmd_go  = wr_en && paddr == `CFA_CMD_OFS;
  wire        insn_wr = wr_en && paddr == `CFA_INSN_OFS;
  wire [7:0]  alu_res;
  wire [7:0]  alu_flags;
  wire [15:0] ea_w;
  wire [15:0] npc_w;
  wire [1:0]  page_w;
  wire [2:0]  len_w;
  wire        mref_w;
  wire [3:0]  cyc_w;
  wire [`CFA_MSRC-1:0] msk_pend;
  wire [`CFA_MSRC-1:0] lower_pend;

////////////////////////////////////////////////////////////////////////////////
// Flag arithmetic and address generation.

  cfa_flag_alu u_alu (
    .op        (cmd_op),
    .a         (oper_q[7:0]),
    .b         (oper_q[15:8]),
    .flags_in  (flags_register),
    .res       (alu_res),
    .flags_out (alu_flags)
  );

  cfa_ea_gen u_ea (
    .insn    (insn_q),
    .pc      (pc_q),
    .ix      (ix_q),
    .iy      (iy_q),
    .mode    (actl_q[2:0]),
    .use_y   (actl_q[3]),
    .wide    (actl_q[4]),
    .taken   (taken),
    .ea      (ea_w),
    .next_pc (npc_w),
    .page    (page_w),
    .len     (len_w),
    .mem_ref (mref_w),
    .cycles  (cyc_w)
  );

////////////////////////////////////////////////////////////////////////////////
// Branch condition against the current flags.

  always @* begin
    // Codes come in pairs; the odd code of a pair branches on the opposite outcome.
    case (actl_q[8:5])
      4'h0: taken = 1'b1;
      4'h1: taken = 1'b0;
      4'h2: taken = ~flags_register[`CFA_F_C];
      4'h3: taken = flags_register[`CFA_F_C];
      4'h4: taken = ~flags_register[`CFA_F_Z];
      4'h5: taken = flags_register[`CFA_F_Z];
      4'h6: taken = ~flags_register[`CFA_F_N];
      4'h7: taken = flags_register[`CFA_F_N];
      4'h8: taken = ~flags_register[`CFA_F_V];
      4'h9: taken = flags_register[`CFA_F_V];
      4'hA: taken = ~(flags_register[`CFA_F_N] ^ flags_register[`CFA_F_V]);
      4'hB: taken = flags_register[`CFA_F_N] ^ flags_register[`CFA_F_V];
      4'hC: taken = ~(flags_register[`CFA_F_Z] |
                      (flags_register[`CFA_F_N] ^ flags_register[`CFA_F_V]));
      4'hD: taken = flags_register[`CFA_F_Z] |
                    (flags_register[`CFA_F_N] ^ flags_register[`CFA_F_V]);
      4'hE: taken = ~(flags_register[`CFA_F_C] | flags_register[`CFA_F_Z]);
      default: taken = flags_register[`CFA_F_C] | flags_register[`CFA_F_Z];
    endcase
  end

////////////////////////////////////////////////////////////////////////////////
// Interrupt gating; source 0 has the highest priority.

  assign nonmaskable_ack = ~nonmaskable_request_pin_n & ~flags_register[`CFA_F_X];

  genvar gi;
  generate
    for (gi = 0; gi < `CFA_MSRC; gi = gi + 1) begin : g_msk
      assign msk_pend[gi] = maskable_req[gi] & ~flags_register[`CFA_F_I];
      if (gi == 0) begin : g_first
        assign lower_pend[gi] = 1'b0;
      end else begin : g_rest
        assign lower_pend[gi] = lower_pend[gi-1] | msk_pend[gi-1];
      end
      // The nonmaskable acknowledge pre-empts any maskable one in the same cycle.
      assign maskable_ack[gi] = msk_pend[gi] & ~lower_pend[gi] & ~nonmaskable_ack;
    end
  endgenerate

////////////////////////////////////////////////////////////////////////////////
// Flag register next value; hardware sets win over software clears.

  always @* begin
    flags_d = flags_register;
    if (cmd_go) begin
      case (cmd_op)
        `CFA_OP_TAP, `CFA_OP_RETURN: begin
          flags_d = pwdata[15:8];
          // Software may clear the nonmaskable mask but can never set it again.
          flags_d[`CFA_F_X] = flags_register[`CFA_F_X] & pwdata[8+`CFA_F_X];
        end
        `CFA_OP_STOP: flags_d = flags_register;
        default: flags_d = alu_flags;
      endcase
    end
    if (|maskable_ack) begin
      flags_d[`CFA_F_I] = 1'b1;
    end
    if (nonmaskable_ack) begin
      flags_d[`CFA_F_X] = 1'b1;
      flags_d[`CFA_F_I] = 1'b1;
    end
  end

  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      flags_register <= `CFA_FLAGS_RST;
    end else begin
      flags_register <= flags_d;
    end
  end

////////////////////////////////////////////////////////////////////////////////
// Command side effects: stop request, status and result capture.

  // The stop pulse lasts one clock; a disabled stop only leaves a trace in the status.
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      res_q <= 8'h00;
      stop_enter <= 1'b0;
      stop_nop_q <= 1'b0;
      last_op_q <= 4'h0;
    end else begin
      stop_enter <= 1'b0;
      if (cmd_go) begin
        last_op_q <= cmd_op;
        if (cmd_op == `CFA_OP_STOP) begin
          stop_enter <= ~flags_register[`CFA_F_S];
          stop_nop_q <= flags_register[`CFA_F_S];
        end else if (cmd_op != `CFA_OP_TAP && cmd_op != `CFA_OP_RETURN) begin
          res_q <= alu_res;
        end
      end
    end
  end

////////////////////////////////////////////////////////////////////////////////
// Instruction decode sequence.

  always @* begin
    case (state_q)
      ST_IDLE:   state_d = insn_wr ? ST_DECODE : ST_IDLE;
      ST_DECODE: state_d = ST_LATCH;
      // A new instruction write while results latch restarts the decode at once.
      ST_LATCH:  state_d = insn_wr ? ST_DECODE : ST_IDLE;
      default:   state_d = ST_IDLE;
    endcase
  end

  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_q <= ST_IDLE;
      ea_q <= 16'h0000;
      page_q <= 2'd0;
      len_q <= 3'd0;
      mref_q <= 1'b0;
      cyc_last_q <= 4'h0;
    end else begin
      state_q <= state_d;
      // Results latch one clock after the instruction write and hold until the next decode.
      if (state_q == ST_DECODE) begin
        ea_q <= ea_w;
        page_q <= page_w;
        len_q <= len_w;
        mref_q <= mref_w;
        cyc_last_q <= cyc_w;
      end
    end
  end

////////////////////////////////////////////////////////////////////////////////
// Running cycle total.

  // A decode in the same cycle as a clearing write takes precedence over the clear.
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cyc_sum_q <= 16'h0000;
    end else if (state_q == ST_DECODE) begin
      cyc_sum_q <= cyc_sum_q + {12'h000, cyc_w};
    end else if (wr_en && paddr == `CFA_CYC_OFS) begin
      cyc_sum_q <= 16'h0000;
    end
  end

////////////////////////////////////////////////////////////////////////////////
// Register writes.

  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      oper_q <= 16'h0000;
      insn_q <= 32'h00000000;
      ix_q <= 16'h0000;
      iy_q <= 16'h0000;
      actl_q <= 9'h000;
    end else begin
      if (wr_en) begin
        case (paddr)
          `CFA_OPER_OFS:  oper_q <= pwdata[15:0];
          `CFA_INSN_OFS:  insn_q <= pwdata;
          `CFA_INDEX_OFS: begin
            ix_q <= pwdata[15:0];
            iy_q <= pwdata[31:16];
          end
          `CFA_ACTL_OFS:  actl_q <= pwdata[8:0];
          default: oper_q <= oper_q;
        endcase
      end
    end
  end

////////////////////////////////////////////////////////////////////////////////
// Program counter: software loads it, each decode advances it.

  // A decode and a software load in one cycle cannot both apply; the decode wins.
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pc_q <= 16'h0000;
    end else if (state_q == ST_DECODE) begin
      pc_q <= npc_w;
    end else if (wr_en && paddr == `CFA_PC_OFS) begin
      pc_q <= pwdata[15:0];
    end
  end

////////////////////////////////////////////////////////////////////////////////
// APB read mux and zero-wait answer.

  always @* begin
    // Reserved bits read as zero and an unmapped offset answers with an error.
    rd_ok = 1'b1;
    case (paddr)
      `CFA_OPER_OFS:  rd_mux = {16'h0000, oper_q};
      `CFA_CMD_OFS:   rd_mux = {23'h000000, stop_nop_q, state_q == ST_IDLE, 3'b000,
                                last_op_q};
      `CFA_FLAGS_OFS: rd_mux = {24'h000000, flags_register};
      `CFA_INSN_OFS:  rd_mux = insn_q;
      `CFA_INDEX_OFS: rd_mux = {iy_q, ix_q};
      `CFA_PC_OFS:    rd_mux = {16'h0000, pc_q};
      `CFA_ACTL_OFS:  rd_mux = {22'h000000, taken, actl_q};
      `CFA_EA_OFS:    rd_mux = {4'h0, cyc_last_q, 2'b00, mref_q, len_q, page_q, ea_q};
      `CFA_CYC_OFS:   rd_mux = {16'h0000, cyc_sum_q};
      `CFA_RES_OFS:   rd_mux = {24'h000000, res_q};
      default: begin
        rd_mux = 32'h00000000;
        rd_ok = 1'b0;
      end
    endcase
  end

  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      // Zero wait states: every setup cycle is answered in the very next cycle.
      pready <= setup;
      pslverr <= setup & ~rd_ok;
      if (setup) begin
        prdata <= pwrite ? 32'h00000000 : rd_mux;
      end
    end
  end

endmodule

// File: verif/cfa_irq_model.sv
`timescale 1ns/1ps
`include "cfa_regs.vh"
module cfa_irq_model (
  input  wire                 ref_clk,
  input  wire                 reset,
  input  wire [`CFA_MSRC-1:0] raise_m,
  input  wire                 raise_x,
  input  wire [`CFA_MSRC-1:0] maskable_ack,
  input  wire                 nonmaskable_ack,
  output reg  [`CFA_MSRC-1:0] maskable_req,
  output reg                  pin_n
);
  // Each source holds its level request until the core acknowledges it.
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      maskable_req <= '0;
      pin_n        <= 1'b1;
    end else begin
      maskable_req <= (maskable_req | raise_m) & ~maskable_ack;
      pin_n        <= ~((~pin_n | raise_x) & ~nonmaskable_ack);
    end
  end
endmodule

// File: verif/cfa_core_assertions.sv
`timescale 1ns/1ps
`include "cfa_regs.vh"
module cfa_core_assertions (
  input wire                 ref_clk,
  input wire                 reset,
  input wire                 psel,
  input wire                 penable,
  input wire                 pwrite,
  input wire [7:0]           paddr,
  input wire [31:0]          pwdata,
  input wire                 pready,
  input wire                 nonmaskable_request_pin_n,
  input wire [`CFA_MSRC-1:0] maskable_ack,
  input wire                 nonmaskable_ack,
  input wire                 stop_enter,
  input wire [7:0]           flags_register
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  reg  [15:0] oper_q;
  wire        wr_ok  = psel && penable && pwrite && pready;
  wire        cmd_wr = wr_ok && paddr == `CFA_CMD_OFS;
  wire [3:0]  op     = pwdata[3:0];
  wire [8:0]  sum    = oper_q[7:0] + oper_q[15:8];
  wire        h_add  = (oper_q[3:0] + oper_q[11:8]) > 5'h0F;
  wire        v_add  = oper_q[7] == oper_q[15] && sum[7] != oper_q[7];
  wire [4:0]  add_f  = {h_add, sum[7], sum[7:0] == 8'h00, v_add, sum[8]};
  wire        x_clr  = cmd_wr && (op == `CFA_OP_TAP || op == `CFA_OP_RETURN);
  wire        go     = cmd_wr && op == `CFA_OP_STOP && !flags_register[`CFA_F_S];
  ////////////////////////////////////////////////////////////
  // Shadow of the operand register, so flag outcomes can be predicted.
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      oper_q <= 16'h0000;
    end else if (wr_ok && paddr == `CFA_OPER_OFS) begin
      oper_q <= pwdata[15:0];
    end
  end
  sequence s_stop(sbit);
    cmd_wr && op == `CFA_OP_STOP && flags_register[`CFA_F_S] == sbit;
  endsequence
  ////////////////////////////////////////////////////////////
  a_add_flags: assert property (
    cmd_wr && op == `CFA_OP_ADD |=> {flags_register[5], flags_register[3:0]} == $past(add_f))
    else $error("add flags wrong");
  a_mask_block: assert property (
    flags_register[`CFA_F_I] |-> maskable_ack == '0)
    else $error("maskable ack while masked");
  a_xmask_set: assert property (
    $rose(flags_register[`CFA_F_X]) |-> $past(nonmaskable_ack))
    else $error("x mask set without ack");
  a_xmask_clear: assert property (
    $fell(flags_register[`CFA_F_X]) |-> $past(x_clr))
    else $error("x mask cleared without command");
  a_xack_masks: assert property (
    nonmaskable_ack |-> !nonmaskable_request_pin_n ##1 (flags_register[6] && flags_register[4]))
    else $error("nonmaskable ack did not set masks");
  a_stop_run: assert property (
    s_stop(1'b0) |=> stop_enter ##1 !stop_enter)
    else $error("stop pulse missing");
  a_stop_nop: assert property (
    s_stop(1'b1) |=> !stop_enter)
    else $error("stop ran while disabled");
  a_stop_cause: assert property (
    stop_enter |-> $past(go))
    else $error("stop pulse without command");
endmodule
bind cfa_core cfa_core_assertions u_chk (
  .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .stop_enter(stop_enter),
  .nonmaskable_request_pin_n(nonmaskable_request_pin_n), .maskable_ack(maskable_ack),
  .nonmaskable_ack(nonmaskable_ack), .flags_register(flags_register)
);

// File: verif/tb_cpu_flags_and_addressing.sv
`timescale 1ns/1ps
`include "cfa_regs.vh"
module tb_cpu_flags_and_addressing;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  logic                 ref_clk = 1'b0;
  logic                 reset   = 1'b1;
  logic                 psel    = 1'b0;
  logic                 penable = 1'b0;
  logic                 pwrite  = 1'b0;
  logic [7:0]           paddr   = 8'h00;
  logic [31:0]          pwdata  = 32'h0;
  logic [`CFA_MSRC-1:0] raise_m = '0;
  logic                 raise_x = 1'b0;
  logic [31:0]          prdata;
  logic                 pready;
  logic                 pslverr;
  logic [`CFA_MSRC-1:0] m_req;
  logic [`CFA_MSRC-1:0] m_ack;
  logic                 pin_n;
  logic                 x_ack;
  logic                 stop_enter;
  logic [31:0]          rdat;
  logic                 rerr;
  int                   failures = 0;
  int                   samples_checked = 0;
  int                   m_cnt = 0;
  int                   x_cnt = 0;
  int                   s_cnt = 0;
  // Rows are operation, operand b, operand a, flags after, result.
  logic [35:0] alu_t [0:8] = '{36'h0_08_08_20_10, 36'h0_01_7F_2A_80, 36'h0_01_FF_25_00,
    36'h1_00_0F_20_10, 36'hC_80_80_07_00, 36'h2_01_00_09_FF, 36'h4_0F_F0_05_00,
    36'h2_01_80_02_7F, 36'h7_00_81_03_02};
  // Rows are pc, instruction bytes, mode control, result word, mask, next pc.
  logic [31:0] ea_t [0:6][0:5] = '{
    '{32'h1000, 32'h3412CE18, 32'h10, 32'h04111002, 32'hFFDFFFFF, 32'h1004},
    '{32'h1000, 32'h00008096, 32'h01, 32'h03280080, ALL, 32'h1002},
    '{32'h1000, 32'h3412B61A, 32'h02, 32'h05321234, ALL, 32'h1004},
    '{32'h1000, 32'h00F0A6CD, 32'h0B, 32'h052F00E0, ALL, 32'h1003},
    '{32'h1000, 32'h0000001B, 32'h04, 32'h02040000, 32'hFFFF0000, 32'h1001},
    '{32'hFFF0, 32'h00007F20, 32'h05, 32'h03080071, 32'hFFDFFFFF, 32'h0071},
    '{32'h1000, 32'h00001021, 32'h25, 32'h03080000, 32'hFFDF0000, 32'h1002}};
  cfa_core dut (
    .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .nonmaskable_request_pin_n(pin_n), .maskable_req(m_req), .maskable_ack(m_ack),
    .nonmaskable_ack(x_ack), .stop_enter(stop_enter), .flags_register());
  cfa_irq_model u_src (
    .ref_clk(ref_clk), .reset(reset), .raise_m(raise_m), .raise_x(raise_x),
    .maskable_ack(m_ack), .nonmaskable_ack(x_ack), .maskable_req(m_req), .pin_n(pin_n));
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (!reset) begin
      m_cnt <= m_cnt + (m_ack != '0);
      x_cnt <= x_cnt + x_ack;
      s_cnt <= s_cnt + stop_enter;
    end
  end
  ////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    begin
      samples_checked++;
      if (got !== exp) begin
        failures++;
        $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    begin
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      while (pready !== 1'b1) begin
        @(posedge ref_clk);
      end
      rdat = prdata;
      rerr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
    end
  endtask
  task rdc(input string nm, input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    begin
      apb(1'b0, a, 32'h0);
      chk(nm, rdat & m, e & m);
    end
  endtask
  task final_report;
    begin
      $display("checked %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
        $display("STATUS OK");
      end else begin
        $display("STATUS NOT OK");
      end
      $finish;
    end
  endtask
  initial begin
    repeat (5000) @(posedge ref_clk);
    failures++;
    final_report;
  end
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    rdc("flags_rst", `CFA_FLAGS_OFS, 32'hD0, ALL);
    apb(1'b1, `CFA_FLAGS_OFS, 32'hFF);
    rdc("flags_ro", `CFA_FLAGS_OFS, 32'hD0, ALL);
    rdc("unmapped", 8'h30, 32'h0, ALL);
    chk("slverr", rerr, 32'h1);
    raise_m <= 2'h1;
    raise_x <= 1'b1;
    @(posedge ref_clk);
    raise_m <= 2'h0;
    raise_x <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk("acks_masked", m_cnt + x_cnt, 0);
    apb(1'b1, `CFA_CMD_OFS, 32'h0D);
    repeat (2) @(posedge ref_clk);
    rdc("x_ack_flags", `CFA_FLAGS_OFS, 32'h50, ALL);
    chk("x_acks", x_cnt + m_cnt, 1);
    apb(1'b1, `CFA_CMD_OFS, 32'h0E);
    repeat (2) @(posedge ref_clk);
    rdc("m_ack_flags", `CFA_FLAGS_OFS, 32'h10, ALL);
    chk("m_acks", m_cnt, 1);
    apb(1'b1, `CFA_CMD_OFS, 32'h400D);
    rdc("x_no_set", `CFA_FLAGS_OFS, 32'h00, ALL);
    foreach (alu_t[i]) begin
      apb(1'b1, `CFA_OPER_OFS, {16'h0, alu_t[i][31:16]});
      apb(1'b1, `CFA_CMD_OFS, {28'h0, alu_t[i][35:32]});
      rdc("alu_res", `CFA_RES_OFS, {24'h0, alu_t[i][7:0]}, ALL);
      rdc("alu_flags", `CFA_FLAGS_OFS, {24'h0, alu_t[i][15:8]}, ALL);
    end
    apb(1'b1, `CFA_CMD_OFS, 32'h0F);
    apb(1'b1, `CFA_CMD_OFS, 32'h800D);
    apb(1'b1, `CFA_CMD_OFS, 32'h0F);
    chk("stops", s_cnt, 1);
    rdc("stop_nop", `CFA_CMD_OFS, 32'h10F, 32'h10F);
    apb(1'b1, `CFA_INDEX_OFS, 32'hFFF0_0000);
    foreach (ea_t[i]) begin
      apb(1'b1, `CFA_PC_OFS, ea_t[i][0]);
      apb(1'b1, `CFA_ACTL_OFS, ea_t[i][2]);
      apb(1'b1, `CFA_INSN_OFS, ea_t[i][1]);
      repeat (2) @(posedge ref_clk);
      rdc("ea", `CFA_EA_OFS, ea_t[i][3], ea_t[i][4]);
      rdc("next_pc", `CFA_PC_OFS, ea_t[i][5], ALL);
    end
    rdc("cyc_sum", `CFA_CYC_OFS, 32'h19, ALL);
    apb(1'b1, `CFA_CYC_OFS, 32'h0);
    rdc("cyc_clr", `CFA_CYC_OFS, 32'h0, ALL);
    apb(1'b1, `CFA_ACTL_OFS, 32'h85);
    rdc("cond_ne", `CFA_ACTL_OFS, 32'h285, ALL);
    apb(1'b1, `CFA_ACTL_OFS, 32'hA5);
    rdc("cond_eq", `CFA_ACTL_OFS, 32'h0A5, ALL);
    final_report;
  end
endmodule
